// ### rtl/adsc_pkg.sv
package adsc_pkg;

    // Clock and timing
    localparam int MCLK_PERIOD_NS = 100;
    localparam int DEB_HIGH_TIME_NS = 1000;
    localparam int DEB_LOW_TIME_NS = 1000;
    localparam int CMP_SETTLE_TIME_NS = 300;
    localparam int DEB_HIGH_CYC = (DEB_HIGH_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int DEB_LOW_CYC = (DEB_LOW_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int CMP_SETTLE_CYC = (CMP_SETTLE_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

    // Input address codes
    localparam logic [3:0] ADDR_LAST_CHAN = 4'ha;
    localparam logic [3:0] ADDR_REF_MID = 4'hb;
    localparam logic [3:0] ADDR_REF_LOW = 4'hc;
    localparam logic [3:0] ADDR_REF_HIGH = 4'hd;
    localparam logic [3:0] ADDR_POWER_DOWN = 4'he;

    // Command field positions in the four bits after the address
    localparam int FLD_LEN_HIGH = 3;
    localparam int FLD_LEN_LOW = 2;
    localparam int FLD_LSB_FIRST = 1;
    localparam int FLD_BIPOLAR = 0;

    // Transfer lengths and address/command capture edges, in clock pulses
    localparam logic [4:0] LEN_8 = 5'h08;
    localparam logic [4:0] LEN_12 = 5'h0c;
    localparam logic [4:0] LEN_16 = 5'h10;
    localparam logic [4:0] ADDR_EDGE = 5'h04;
    localparam logic [4:0] CMD_EDGE = 5'h08;

    // Converter
    localparam int RES_BITS = 12;
    localparam logic [11:0] CODE_FULL = 12'hfff;
    localparam logic [11:0] CODE_ZERO = 12'h000;
    localparam logic [11:0] CODE_MSB_TRIAL = 12'h800;
    localparam logic [3:0] STEP_MSB = 4'hb;
    localparam logic [15:0] WORD_RST = 16'h0000;

    // Approximation sequencer states
    typedef enum logic [3:0] {
        SAR_IDLE = 4'b0001,
        SAR_WAIT = 4'b0010,
        SAR_LATCH = 4'b0100,
        SAR_SPARE = 4'b1000
    } adsc_sar_t;

endpackage : adsc_pkg

// ### rtl/adsc_sync2.sv
module adsc_sync2 (
    input wire logic clk,
    input wire logic rst,
    input wire logic d,
    output logic q
);

    logic meta_r;

    // Two stages; only the second stage is read outside
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end

endmodule // adsc_sync2

// ### rtl/adsc_top.sv
module adsc_top
    import adsc_pkg::*;
#(
    parameter int DEB_HIGH_COUNT = DEB_HIGH_CYC,
    parameter int DEB_LOW_COUNT = DEB_LOW_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic io_clk,
    input wire logic din,
    output logic dout,
    output logic dout_oe_n,
    output logic eoc,
    output logic [3:0] chan_sel,
    output logic samp_en,
    output logic standby,
    output logic [11:0] dac_code,
    input wire logic cmp_trial_high,
    input wire logic in_above_upper,
    input wire logic in_below_lower
);

    ////////////////////////////////////////////////////////////////////////
    // Internal clock domain: select handling

    logic cs_s;
    logic cs_act_s;
    logic cmp_s;
    logic above_s;
    logic below_s;
    logic frame_tgl_s;
    logic addr_tgl_s;
    logic dout_oe_n_r;
    logic cs_deb_r;
    logic [11:0] deb_cnt_r;
    logic link_rst_r;
    logic frame_tgl_d_r;
    logic addr_tgl_d_r;
    logic standby_r;
    logic frame_evt;
    logic addr_evt;

    // Link-domain registers, read here only after their toggle event
    logic [3:0] addr_r;
    logic [3:0] cmd_r;
    logic frame_tgl_r;
    logic addr_tgl_r;

    // Select synchronised inverted, so reset leaves it deselected, not selected
    adsc_sync2 u_sync_cs (
        .clk(mclk),
        .rst(rst),
        .d(~cs_n),
        .q(cs_act_s)
    );

    assign cs_s = ~cs_act_s;

    adsc_sync2 u_sync_cmp (
        .clk(mclk),
        .rst(rst),
        .d(cmp_trial_high),
        .q(cmp_s)
    );

    adsc_sync2 u_sync_above (
        .clk(mclk),
        .rst(rst),
        .d(in_above_upper),
        .q(above_s)
    );

    adsc_sync2 u_sync_below (
        .clk(mclk),
        .rst(rst),
        .d(in_below_lower),
        .q(below_s)
    );

    adsc_sync2 u_sync_frame (
        .clk(mclk),
        .rst(rst),
        .d(frame_tgl_r),
        .q(frame_tgl_s)
    );

    adsc_sync2 u_sync_addr (
        .clk(mclk),
        .rst(rst),
        .d(addr_tgl_r),
        .q(addr_tgl_s)
    );

    // Output released as soon as the synchronised select is high
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dout_oe_n_r <= 1'b1;
        end else begin
            dout_oe_n_r <= cs_s;
        end
    end

    // Debounce: the level must hold for the full count before it is taken
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cs_deb_r <= 1'b1;
            deb_cnt_r <= 12'h000;
        end else if (cs_s == cs_deb_r) begin
            deb_cnt_r <= 12'h000;
        end else if (deb_cnt_r == (cs_s ? 12'(DEB_HIGH_COUNT - 1) : 12'(DEB_LOW_COUNT - 1))) begin
            cs_deb_r <= cs_s;
            deb_cnt_r <= 12'h000;
        end else begin
            deb_cnt_r <= deb_cnt_r + 12'h001;
        end
    end

    // Link logic held in reset while debounced high, released when debounced low
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            link_rst_r <= 1'b1;
        end else begin
            link_rst_r <= cs_deb_r;
        end
    end

    // Toggle events from the link domain
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            frame_tgl_d_r <= 1'b0;
            addr_tgl_d_r <= 1'b0;
        end else begin
            frame_tgl_d_r <= frame_tgl_s;
            addr_tgl_d_r <= addr_tgl_s;
        end
    end

    assign frame_evt = frame_tgl_s ^ frame_tgl_d_r;
    assign addr_evt = addr_tgl_s ^ addr_tgl_d_r;

    // Standby from reset; events ignored while the link is held, as its toggle reset mimics one
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            standby_r <= 1'b1;
        end else if (addr_evt && !link_rst_r) begin
            standby_r <= (addr_r == ADDR_POWER_DOWN);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Internal clock domain: successive approximation

    adsc_sar_t state_r;
    logic eoc_r;
    logic [11:0] dac_r;
    logic [3:0] step_r;
    logic [7:0] wait_r;
    logic conv_lsbf_r;
    logic conv_bip_r;
    logic [4:0] conv_len_r;
    logic [15:0] out_word_r;
    logic out_lsbf_r;
    logic [4:0] out_len_r;
    logic [11:0] res_sat;
    logic [11:0] res_fmt;

    function automatic logic [4:0] len_of(input logic [1:0] sel);
        if (!sel[0]) begin
            return LEN_12;
        end else if (sel[1]) begin
            return LEN_16;
        end
        return LEN_8;
    endfunction

    // Clamp at the references, then apply the sign format
    always_comb begin
        if (above_s) begin
            res_sat = CODE_FULL;
        end else if (below_s) begin
            res_sat = CODE_ZERO;
        end else begin
            res_sat = dac_r;
        end
        res_fmt = {res_sat[11] ^ conv_bip_r, res_sat[10:0]};
    end

    // Sequencer; standby and a held link block any start
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_r <= SAR_IDLE;
            eoc_r <= 1'b1;
            dac_r <= CODE_ZERO;
            step_r <= STEP_MSB;
            wait_r <= 8'h00;
            conv_lsbf_r <= 1'b0;
            conv_bip_r <= 1'b0;
            conv_len_r <= LEN_12;
        end else begin
            case (state_r)
                SAR_IDLE: begin
                    if (frame_evt && !standby_r && !cs_deb_r && !link_rst_r) begin
                        eoc_r <= 1'b0;
                        dac_r <= CODE_MSB_TRIAL;
                        step_r <= STEP_MSB;
                        wait_r <= 8'h00;
                        conv_lsbf_r <= cmd_r[FLD_LSB_FIRST];
                        conv_bip_r <= cmd_r[FLD_BIPOLAR];
                        conv_len_r <= len_of(cmd_r[FLD_LEN_HIGH:FLD_LEN_LOW]);
                        state_r <= SAR_WAIT;
                    end
                end
                SAR_WAIT: begin
                    if (cs_deb_r) begin
                        // Aborted: old result word untouched
                        eoc_r <= 1'b1;
                        state_r <= SAR_IDLE;
                    end else if (wait_r == 8'(CMP_SETTLE_CYC + 1)) begin
                        // Extra cycles cover the comparator synchroniser
                        wait_r <= 8'h00;
                        if (cmp_s) begin
                            dac_r[step_r] <= 1'b0;
                        end
                        if (step_r == 4'h0) begin
                            state_r <= SAR_LATCH;
                        end else begin
                            dac_r[step_r - 4'h1] <= 1'b1;
                            step_r <= step_r - 4'h1;
                        end
                    end else begin
                        wait_r <= wait_r + 8'h01;
                    end
                end
                SAR_LATCH: begin
                    eoc_r <= 1'b1;
                    state_r <= SAR_IDLE;
                end
                default: begin
                    state_r <= SAR_IDLE;
                    eoc_r <= 1'b1;
                end
            endcase
        end
    end

    // Output word, left justified; short mode drops four LSBs, long pads zeros
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            out_word_r <= WORD_RST;
            out_lsbf_r <= 1'b0;
            out_len_r <= LEN_12;
        end else if (state_r == SAR_LATCH) begin
            out_word_r <= (conv_len_r == LEN_8) ? {res_fmt[11:4], 8'h00} : {res_fmt, 4'h0};
            out_lsbf_r <= conv_lsbf_r;
            out_len_r <= conv_len_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link clock domain, reset while select is inhibited

    logic [7:0] in_sr_r;
    logic [4:0] cnt_r;
    logic [4:0] cnt_nxt;
    logic [4:0] len_now;
    logic end_now;
    logic [3:0] chan_sel_r;
    logic samp_en_r;

    // Address and command bits enter on the rising edge
    always_ff @(posedge io_clk or posedge link_rst_r) begin
        if (link_rst_r) begin
            in_sr_r <= 8'h00;
        end else begin
            in_sr_r <= {in_sr_r[6:0], din};
        end
    end

    assign cnt_nxt = cnt_r + 5'h01;
    assign len_now = (cnt_nxt == CMD_EDGE) ? len_of(in_sr_r[FLD_LEN_HIGH:FLD_LEN_LOW])
        : len_of(cmd_r[FLD_LEN_HIGH:FLD_LEN_LOW]);
    assign end_now = (cnt_nxt >= CMD_EDGE) && (cnt_nxt == len_now);

    // Falling-edge count; wraps at cycle end so select may stay low
    always_ff @(negedge io_clk or posedge link_rst_r) begin
        if (link_rst_r) begin
            cnt_r <= 5'h00;
        end else if (end_now) begin
            cnt_r <= 5'h00;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // Address taken at the fourth falling edge, command at the eighth
    always_ff @(negedge io_clk or posedge link_rst_r) begin
        if (link_rst_r) begin
            addr_r <= ADDR_POWER_DOWN;
            cmd_r <= 4'h0;
            addr_tgl_r <= 1'b0;
        end else begin
            if (cnt_nxt == ADDR_EDGE) begin
                addr_r <= in_sr_r[3:0];
                addr_tgl_r <= ~addr_tgl_r;
            end
            if (cnt_nxt == CMD_EDGE) begin
                cmd_r <= in_sr_r[3:0];
            end
        end
    end

    // Cycle end handed over to the internal clock
    always_ff @(negedge io_clk or posedge link_rst_r) begin
        if (link_rst_r) begin
            frame_tgl_r <= 1'b0;
        end else if (end_now) begin
            frame_tgl_r <= ~frame_tgl_r;
        end
    end

    // Selector: switch is already open since the last hold, so the select
    // lines change with no channel connected
    always_ff @(negedge io_clk or posedge link_rst_r) begin
        if (link_rst_r) begin
            chan_sel_r <= 4'h0;
            samp_en_r <= 1'b0;
        end else if (end_now) begin
            samp_en_r <= 1'b0;
        end else if (cnt_nxt == ADDR_EDGE) begin
            chan_sel_r <= in_sr_r[3:0];
            samp_en_r <= (in_sr_r[3:0] != ADDR_POWER_DOWN);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial output: stable result word indexed by the falling-edge count

    logic [4:0] bit_pos;
    logic bit_val;

    // Word only changes between cycles, so indexing across domains is safe
    always_comb begin
        bit_pos = out_lsbf_r ? (5'h10 - out_len_r + cnt_r) : (5'h0f - cnt_r);
        bit_val = (cnt_r < out_len_r) && (bit_pos < 5'h10) && out_word_r[bit_pos[3:0]];
    end

    // Forced low while converting; first bit present as soon as reset ends
    assign dout = eoc_r & bit_val;
    assign dout_oe_n = dout_oe_n_r;
    assign eoc = eoc_r;
    assign chan_sel = chan_sel_r;
    assign samp_en = samp_en_r;
    assign standby = standby_r;
    assign dac_code = dac_r;

endmodule // adsc_top

// ### dv/adsc_top_props.sv
module adsc_top_props
    import adsc_pkg::*;
#(
    parameter int DEB_HIGH_COUNT = 2,
    parameter int DEB_LOW_COUNT = 2
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic dout_oe_n,
    input wire logic eoc,
    input wire logic [3:0] chan_sel,
    input wire logic samp_en,
    input wire logic standby,
    input wire logic [11:0] dac_code
);
    default clocking dc @(posedge mclk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    // Conversion phases; abort by select is excluded from the hold check
    sequence conv_start;
        $fell(eoc);
    endsequence
    sequence conv_run;
        conv_start ##1 !cs_n [*8];
    endsequence
    oe_release_a: assert property (cs_n [*5] |-> dout_oe_n)
        else $error("output still driven with select high");
    oe_drive_a: assert property (!cs_n [*5] |-> !dout_oe_n)
        else $error("output not driven with select held low");
    reset_state_a: assert property ($fell(rst) |-> eoc && standby)
        else $error("done or standby wrong after reset");
    standby_idle_a: assert property (standby [*3] |-> eoc)
        else $error("conversion running in standby");
    trial_start_a: assert property (conv_start |-> ##[0:2] (dac_code == CODE_MSB_TRIAL))
        else $error("first trial is not the top weight");
    conv_hold_a: assert property (conv_run |-> !eoc)
        else $error("conversion ended too early");
    conv_end_a: assert property (conv_start |-> ##[1:90] eoc)
        else $error("conversion never completed");
    samp_open_a: assert property (!eoc |-> !samp_en)
        else $error("sampling switch closed while converting");
    mux_break_a: assert property ($changed(chan_sel) |-> !$past(samp_en))
        else $error("channel switched while sampling");
endmodule // adsc_top_props

bind adsc_top adsc_top_props #(
    .DEB_HIGH_COUNT(DEB_HIGH_COUNT),
    .DEB_LOW_COUNT(DEB_LOW_COUNT)
) i_adsc_top_props (
    .mclk(mclk), .rst(rst), .cs_n(cs_n), .dout_oe_n(dout_oe_n), .eoc(eoc),
    .chan_sel(chan_sel), .samp_en(samp_en), .standby(standby), .dac_code(dac_code)
);

// ### dv/adsc_host.sv
module adsc_host (
    input wire logic dout,
    input wire logic dout_oe_n,
    output logic io_clk,
    output logic din
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HALF_NS = 32;
    logic last_bit;
    logic line;
    logic [15:0] rx_word;
    event done;
    ////////////////////////////////////////
    // No pull on the line: once released it shows the inverse of the last level
    always @(dout or dout_oe_n) if (!dout_oe_n) last_bit = dout;
    assign line = dout_oe_n ? ~last_bit : dout;
    // Shift clock rests low outside frames
    initial begin
        io_clk = 1'b0;
        din = 1'b0;
    end
    // Whole frame always clocked out, standby or not; din held fixed after bit 8
    task automatic frame(input logic [7:0] cmd, input int n);
        rx_word = 16'h0000;
        for (int i = 0; i < n; i++) begin
            din = (i < 8) ? cmd[7 - i] : 1'b0;
            #HALF_NS io_clk = 1'b1;
            rx_word[15 - i] = line;
            #HALF_NS io_clk = 1'b0;
        end
        -> done;
    endtask
endmodule // adsc_host

// ### dv/adsc_top_bench.sv
module adsc_top_bench;
    import adsc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DEB = 2;
    logic mclk, rst, cs_n, din, dout, dout_oe_n, eoc, samp_en, standby, io_clk;
    logic cmp_trial_high, in_above_upper, in_below_lower, hi, lo;
    logic [3:0] chan_sel;
    logic [11:0] dac_code, vin;
    logic [15:0] pend_e, pend_m;
    logic [31:0] exp_q[$];
    int num_errors, samples_checked;

    adsc_top #(.DEB_HIGH_COUNT(DEB), .DEB_LOW_COUNT(DEB)) i_adsc_top (
        .mclk(mclk), .rst(rst), .cs_n(cs_n), .io_clk(io_clk), .din(din), .dout(dout),
        .dout_oe_n(dout_oe_n), .eoc(eoc), .chan_sel(chan_sel), .samp_en(samp_en), .standby(standby),
        .dac_code(dac_code), .cmp_trial_high(cmp_trial_high), .in_above_upper(in_above_upper),
        .in_below_lower(in_below_lower));
    adsc_host i_adsc_host (.dout(dout), .dout_oe_n(dout_oe_n), .io_clk(io_clk), .din(din));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    ////////////////////////////////////////
    // Analog side; range flags force the comparator like a real out-of-range input
    always @(posedge mclk) begin
        cmp_trial_high <= !hi && (lo || dac_code > vin);
        in_above_upper <= hi;
        in_below_lower <= lo;
    end
    task automatic stop_test();
        $display("checked %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch word at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic check_stat(input logic [3:0] got, input logic [3:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch status at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Bounded wait for done; a hang is a failure
    task automatic wait_eoc();
        int k = 0;
        repeat (8) @(posedge mclk);
        while (eoc !== 1'b1 && k < 200) begin
            @(posedge mclk);
            k++;
        end
        if (eoc !== 1'b1) begin
            num_errors++;
            stop_test();
        end
    endtask
    // One frame; its own result is read back by the following frame
    task automatic xfer(input logic [3:0] a, input logic [3:0] c, input logic [11:0] v, input bit abort);
        int n;
        logic was_sb;
        logic [15:0] w;
        n = (c[3:2] == 2'b01) ? 8 : (c[3:2] == 2'b11) ? 16 : 12;
        was_sb = standby;
        vin <= v;
        @(posedge mclk);
        exp_q.push_back({pend_m & (16'hffff << (16 - n)), pend_e});
        i_adsc_host.frame({a, c}, n);
        if (abort) begin
            repeat (8) @(posedge mclk);
            cs_n <= 1'b1;
            repeat (10) @(posedge mclk);
            @(negedge mclk);
            check_stat({3'h0, dout_oe_n}, 4'h1);
            @(posedge mclk);
            cs_n <= 1'b0;
        end
        wait_eoc();
        @(negedge mclk);
        if (!abort) begin
            check_stat({3'h0, standby}, {3'h0, a == 4'he});
            if (a != 4'he) begin
                check_stat(chan_sel, a);
                pend_e = {(hi ? 12'hfff : lo ? 12'h000 : v) ^ {c[0], 11'h000}, 4'h0};
                w = pend_e;
                if (c[1]) begin
                    // Least significant first: the n-bit stream comes out reversed
                    for (int i = 0; i < n; i++) begin
                        pend_e[15 - i] = w[16 - n + i];
                    end
                end
                pend_m = (n == 8) ? 16'hff00 : (n == 12) ? 16'hfff0 : 16'hffff;
                if (was_sb) pend_m = 16'h0000;
            end
        end
        repeat (DEB + 10) @(posedge mclk);
    endtask
    // Result watcher: oldest note against each received word
    initial begin
        logic [31:0] e;
        forever begin
            @(i_adsc_host.done);
            e = exp_q.pop_front();
            check_word(i_adsc_host.rx_word & e[31:16], e[15:0] & e[31:16]);
        end
    end
    initial begin
        void'($urandom(82476));
        {rst, cs_n, hi, lo, vin} = {1'b1, 1'b1, 2'b00, 12'h000};
        {cmp_trial_high, in_above_upper, in_below_lower} = 3'b000;
        {pend_e, pend_m, num_errors, samples_checked} = '0;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        check_stat({3'h0, standby}, 4'h1);
        check_stat({3'h0, eoc}, 4'h1);
        @(posedge mclk);
        cs_n <= 1'b0;
        repeat (DEB + 10) @(posedge mclk);
        check_stat({3'h0, dout_oe_n}, 4'h0);
        for (int a = 0; a < 14; a++) begin
            xfer(4'(a), {a[0], a[0], 2'b00}, 12'($urandom), 0);
        end
        hi <= 1'b1;
        xfer(4'h5, 4'hc, 12'h123, 0);
        {hi, lo} <= 2'b01;
        xfer(4'h6, 4'h4, 12'h456, 0);
        lo <= 1'b0;
        xfer(4'he, 4'hc, 12'h000, 0);
        xfer(4'h2, 4'hc, 12'($urandom), 0);
        xfer(4'h3, 4'hc, 12'($urandom), 0);
        xfer(4'h7, 4'h0, 12'h800, 1);
        cs_n <= 1'b1;
        repeat (10) @(posedge mclk);
        check_stat({3'h0, dout_oe_n}, 4'h1);
        cs_n <= 1'b0;
        repeat (DEB + 10) @(posedge mclk);
        xfer(4'h1, 4'hc, 12'($urandom), 0);
        xfer(4'h0, 4'hc, 12'h000, 0);
        xfer(4'h8, 4'hb, 12'($urandom), 0);
        xfer(4'h9, 4'hf, 12'($urandom), 0);
        xfer(4'ha, 4'h6, 12'($urandom), 0);
        xfer(4'h4, 4'h0, 12'($urandom), 0);
        repeat (4) @(posedge mclk);
        stop_test();
    end
endmodule // adsc_top_bench
